// ### rtl/ext_mem_ctrl.sv
/*
 * External data memory steering and strobe timing: picks on-chip or off-chip for
 * each external move, forms the address and runs the setup, strobe and hold phases.
 * Assumes the core issues one move at a time and waits for move_done.
 */
`timescale 1ns/10ps
module ext_mem_ctrl
  import ext_mem_pkg::*;
#(
  parameter int RAM_AW = 12
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic move_valid,
  input wire move_req_t move_req,
  output logic move_busy,
  output logic move_done,
  output logic [7:0] move_rdata,
  input wire logic [7:0] ext_data_i,
  output ext_pins_t ext_pins
);

  // ****************************************************************
  // Special registers
  // ****************************************************************
  logic [7:0] timing_q;
  logic [7:0] config_q;
  logic [7:0] page_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timing_q <= TIMING_RESET;
      config_q <= CONFIG_RESET;
      page_q <= PAGE_RESET;
    end else if (sfr_wr) begin
      if (sfr_addr == TIMING_OFFSET) begin
        timing_q <= sfr_wdata;
      end else if (sfr_addr == CONFIG_OFFSET) begin
        config_q <= sfr_wdata & CONFIG_MASK;
      end else if (sfr_addr == PAGE_OFFSET) begin
        page_q <= sfr_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_rdata <= '0;
    end else if (sfr_addr == TIMING_OFFSET) begin
      sfr_rdata <= timing_q;
    end else if (sfr_addr == CONFIG_OFFSET) begin
      sfr_rdata <= config_q;
    end else if (sfr_addr == PAGE_OFFSET) begin
      sfr_rdata <= page_q;
    end else begin
      sfr_rdata <= '0;
    end
  end

  mem_mode_t mode;
  logic mux_en;
  logic [1:0] latch_sel;
  logic [1:0] setup_sel;
  logic [3:0] strobe_sel;
  logic [1:0] hold_sel;
  assign mode = mem_mode_t'(config_q[MODE_LSB +: 2]);
  assign mux_en = config_q[MUX_BIT];
  assign latch_sel = config_q[LATCH_LSB +: 2];
  assign setup_sel = timing_q[SETUP_LSB +: 2];
  assign strobe_sel = timing_q[STROBE_LSB +: 4];
  assign hold_sel = timing_q[HOLD_LSB +: 2];

  // ****************************************************************
  // Address steering
  // ****************************************************************
  logic [15:0] eff_addr;
  logic above_ram;
  logic off_chip;
  logic hi_drive;

  // wide moves use the data pointer; narrow moves page plus indirect
  assign eff_addr = move_req.wide ? move_req.data_pointer : {page_q, move_req.ind_addr};
  assign above_ram = |eff_addr[15:RAM_AW];
  always_comb begin
    case (mode)
      MODE_INT_ONLY: off_chip = 1'b0;
      MODE_EXT_ONLY: off_chip = 1'b1;
      default: off_chip = above_ram;
    endcase
  end
  // narrow moves leave the high byte to the port latches, except in split-bank mode
  assign hi_drive = move_req.wide || (mode == MODE_SPLIT_BANK);

  typedef struct packed {
    logic wr;
    logic hi_drive;
    logic [15:0] addr;
    logic [7:0] wdata;
  } acc_t;

  acc_t acc_q;
  acc_state_t state_q;
  acc_state_t state_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic idle_take;
  assign idle_take = (state_q == ST_IDLE) && move_valid;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
    end else if (idle_take) begin
      acc_q.wr <= move_req.wr;
      acc_q.hi_drive <= hi_drive;
      acc_q.addr <= eff_addr;
      acc_q.wdata <= move_req.wdata;
    end
  end

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  // latch and strobe phases count down from their select code, setup and hold from one less
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (move_valid) begin
          state_d = off_chip ? ST_START : ST_INT;
        end
      end
      ST_INT: state_d = ST_INT_CAP;
      ST_INT_CAP: state_d = ST_IDLE;
      ST_START: begin
        if (mux_en) begin
          state_d = ST_ALE_HI;
          cnt_d = {2'b00, latch_sel};
        end else if (setup_sel != 2'b00) begin
          state_d = ST_SETUP;
          cnt_d = {2'b00, setup_sel - 2'b01};
        end else begin
          state_d = ST_STROBE;
          cnt_d = strobe_sel;
        end
      end
      ST_ALE_HI: begin
        if (cnt_q == 4'h0) begin
          state_d = ST_ALE_LO;
          cnt_d = {2'b00, latch_sel};
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      ST_ALE_LO, ST_SETUP: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (state_q == ST_ALE_LO && setup_sel != 2'b00) begin
          state_d = ST_SETUP;
          cnt_d = {2'b00, setup_sel - 2'b01};
        end else begin
          state_d = ST_STROBE;
          cnt_d = strobe_sel;
        end
      end
      ST_STROBE: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else if (hold_sel != 2'b00) begin
          state_d = ST_HOLD;
          cnt_d = {2'b00, hold_sel - 2'b01};
        end else begin
          state_d = ST_TAIL;
          cnt_d = 4'(TAIL_CLKS - 1);
        end
      end
      ST_HOLD: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          state_d = ST_TAIL;
          cnt_d = 4'(TAIL_CLKS - 1);
        end
      end
      ST_TAIL: begin
        if (cnt_q != 4'h0) begin
          cnt_d = cnt_q - 4'h1;
        end else begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ****************************************************************
  // Internal RAM and read data
  // ****************************************************************
  logic [7:0] ram_rdata;
  logic [7:0] data_s1_q;
  logic [7:0] data_s2_q;

  // low address bits only, so higher addresses alias
  int_data_ram #(.AW(RAM_AW), .DW(8)) u_ram (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .en(state_q == ST_INT),
    .we(acc_q.wr),
    .addr(acc_q.addr[RAM_AW-1:0]),
    .wdata(acc_q.wdata),
    .rdata(ram_rdata)
  );

  // Pin data crosses two flops; the partner must hold it through the tail
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_s1_q <= '0;
      data_s2_q <= '0;
    end else begin
      data_s1_q <= ext_data_i;
      data_s2_q <= data_s1_q;
    end
  end

  // done follows the fixed four-clock overhead off chip, and ST_INT_CAP for on-chip moves
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      move_done <= 1'b0;
      move_rdata <= '0;
      move_busy <= 1'b0;
    end else begin
      move_busy <= (state_d != ST_IDLE);
      move_done <= (state_q == ST_INT_CAP) || (state_q == ST_TAIL && cnt_q == 4'h0);
      if (state_q == ST_INT_CAP && !acc_q.wr) begin
        move_rdata <= ram_rdata;
      end else if (state_q == ST_TAIL && cnt_q == 4'h0 && !acc_q.wr) begin
        move_rdata <= data_s2_q;
      end
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  logic drive_d;
  logic ale_ph_d;
  assign drive_d = state_d inside {ST_ALE_HI, ST_ALE_LO, ST_SETUP, ST_STROBE, ST_HOLD};
  assign ale_ph_d = state_d inside {ST_ALE_HI, ST_ALE_LO};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_pins <= '{addr: '0, addr_hi_oe: 1'b0, addr_lo_oe: 1'b0, data: '0,
                    data_oe: 1'b0, ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1};
    end else begin
      ext_pins.addr <= acc_q.addr;
      ext_pins.addr_hi_oe <= drive_d && acc_q.hi_drive;
      ext_pins.addr_lo_oe <= drive_d && !mux_en;
      ext_pins.data <= ale_ph_d ? acc_q.addr[7:0] : acc_q.wdata;
      ext_pins.data_oe <= (ale_ph_d && mux_en) || (drive_d && !ale_ph_d && acc_q.wr);
      ext_pins.ale <= (state_d == ST_ALE_HI);
      ext_pins.rd_n <= !(state_d == ST_STROBE && !acc_q.wr);
      ext_pins.wr_n <= !(state_d == ST_STROBE && acc_q.wr);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [7:0] busy_cnt_q;
  logic [4:0] strobe_len_q;
  logic [2:0] ale_len_q;
  logic [7:0] expect_len;
  logic strobe_on;
  assign strobe_on = !ext_pins.rd_n || !ext_pins.wr_n;
  assign expect_len = 8'(int'(setup_sel) + int'(strobe_sel) + 1 + int'(hold_sel)
                      + OVERHEAD_CLKS - 1 + (mux_en ? 2 * (int'(latch_sel) + 1) : 0));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_q <= '0;
      strobe_len_q <= '0;
      ale_len_q <= '0;
    end else begin
      busy_cnt_q <= (state_q == ST_IDLE) ? 8'h00 : busy_cnt_q + 8'h01;
      strobe_len_q <= strobe_on ? strobe_len_q + 5'h01 : 5'h00;
      ale_len_q <= ext_pins.ale ? ale_len_q + 3'h1 : 3'h0;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence setup_one_s;
    state_q == ST_SETUP ##1 state_q == ST_STROBE;
  endsequence

  a_internal_stays_on: assert property (
    idle_take && mode == MODE_INT_ONLY |=> state_q == ST_INT ##1 state_q == ST_INT_CAP)
    else $error("internal-only access left the chip");
  a_wrap_low_bits: assert property (
    idle_take && !move_req.wide && mode == MODE_INT_ONLY
    |=> acc_q.addr[RAM_AW-1:0] == $past(eff_addr[RAM_AW-1:0]))
    else $error("internal address not wrapped");
  a_ext_only_off: assert property (
    idle_take && mode == MODE_EXT_ONLY |=> state_q == ST_START)
    else $error("external-only access stayed on chip");
  a_access_len: assert property (
    move_done && busy_cnt_q > 8'(INT_CLKS) |-> busy_cnt_q == $past(expect_len))
    else $error("off-chip access length wrong");
  a_strobe_width: assert property (
    $fell(strobe_on) |-> $past(strobe_len_q) == 5'($past(strobe_sel)) + 5'h00)
    else $error("strobe width differs from select");
  a_ale_width: assert property (
    $fell(ext_pins.ale) |-> $past(ale_len_q) == 3'($past(latch_sel)) + 3'h0)
    else $error("latch pulse width wrong");
  a_setup_one: assert property (
    state_q == ST_START && !mux_en && setup_sel == 2'b01 |=> setup_one_s)
    else $error("one-clock setup not honoured");
  a_hi_undriven: assert property (
    strobe_on && !acc_q.hi_drive |-> !ext_pins.addr_hi_oe)
    else $error("upper address driven for narrow move");
  a_wide_full_addr: assert property (
    idle_take && off_chip && move_req.wide ##1 state_q != ST_IDLE [*1] ##0 1
    |-> ##[1:40] (strobe_on && ext_pins.addr_hi_oe && ext_pins.addr == $past(acc_q.addr)))
    else $error("wide off-chip access lacks full address");
  a_timing_reset: assert property (
    $rose(rst_n) |-> timing_q == TIMING_RESET)
    else $error("timing register not all ones after reset");

endmodule : ext_mem_ctrl

// ### rtl/ext_mem_pkg.sv
/*
 * Constants, modes, states and carrier types for the external data memory
 * steering and strobe-timing block.
 * Assumes one 250 MHz system clock and a byte-wide special register port.
 */
package ext_mem_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] TIMING_OFFSET = 8'h84;
  localparam logic [7:0] CONFIG_OFFSET = 8'h85;
  localparam logic [7:0] PAGE_OFFSET = 8'haa;
  localparam logic [7:0] TIMING_RESET = 8'hff;
  localparam logic [7:0] CONFIG_RESET = 8'h03;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  // Bits 7:5 of the config register read as zero
  localparam logic [7:0] CONFIG_MASK = 8'h1f;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int MODE_LSB = 2;
  localparam int MUX_BIT = 4;
  localparam int LATCH_LSB = 0;
  localparam int SETUP_LSB = 6;
  localparam int STROBE_LSB = 2;
  localparam int HOLD_LSB = 0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int OVERHEAD_CLKS = 4;
  localparam int TAIL_CLKS = 2;
  localparam int INT_CLKS = 2;

  typedef enum logic [1:0] {
    MODE_INT_ONLY = 2'b00,
    MODE_SPLIT = 2'b01,
    MODE_SPLIT_BANK = 2'b10,
    MODE_EXT_ONLY = 2'b11
  } mem_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_INT = 4'b0001,
    ST_INT_CAP = 4'b0010,
    ST_START = 4'b0011,
    ST_ALE_HI = 4'b0100,
    ST_ALE_LO = 4'b0101,
    ST_SETUP = 4'b0110,
    ST_STROBE = 4'b0111,
    ST_HOLD = 4'b1000,
    ST_TAIL = 4'b1001
  } acc_state_t;

  typedef struct packed {
    logic wr;
    logic wide;
    logic [15:0] data_pointer;
    logic [7:0] ind_addr;
    logic [7:0] wdata;
  } move_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic addr_hi_oe;
    logic addr_lo_oe;
    logic [7:0] data;
    logic data_oe;
    logic ale;
    logic rd_n;
    logic wr_n;
  } ext_pins_t;

endpackage : ext_mem_pkg

// ### rtl/int_data_ram.sv
/*
 * On-chip data RAM with a registered read port.
 * Assumes the caller holds en for one cycle per access; rdata follows a cycle later.
 */
`timescale 1ns/10ps
module int_data_ram #(
  parameter int AW = 12,
  parameter int DW = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem_q [2**AW];

  // Array has no reset; contents are undefined until written
  always_ff @(posedge ref_clk) begin
    if (en && we) begin
      mem_q[addr] <= wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (en && !we) begin
      rdata <= mem_q[addr];
    end
  end

endmodule : int_data_ram

// ### testbench/ext_mem_ctrl_tb.sv
/*
 * Self-checking bench for the external memory steering block.
 * Assumes the behavioural external memory model and one 250 MHz clock.
 */
`timescale 1ns/10ps
module ext_mem_ctrl_tb
  import ext_mem_pkg::*;
;
  typedef struct packed {
    logic rd;
    logic off;
    logic hi;
    logic [7:0] data;
    logic [7:0] lat;
    logic [7:0] sw;
    logic [15:0] addr;
  } exp_t;
  logic ref_clk = 0, rst_n = 0, sfr_wr = 0, move_valid = 0, mux = 0, last_hi_oe;
  logic [7:0] sfr_addr = 0, sfr_wdata = 0, port_hi = 0, sfr_rdata, move_rdata, ext_data_i;
  logic move_busy, move_done;
  move_req_t move_req = '0;
  ext_pins_t ext_pins;
  logic [15:0] last_addr;
  logic [7:0] strobe_len, tmg = 8'hff, page = 8'h00;
  logic [1:0] mode = 2'b00, lw = 2'b11;
  int acc_cnt, acc_prev = 0, mismatches = 0, num_checks = 0, cyc = 0, t0 = 0;
  logic [31:0] rnd = 32'h5d435a75;
  logic [7:0] int_sh [0:4095];
  logic [7:0] ext_sh [0:65535];
  logic [10:0] tcase [0:3] = '{11'h000, 11'h100, 11'h7ff, 11'h040};
  exp_t q[$];
  exp_t e;

  ext_mem_ctrl #(.RAM_AW(12)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .move_valid(move_valid),
    .move_req(move_req), .move_busy(move_busy), .move_done(move_done),
    .move_rdata(move_rdata), .ext_data_i(ext_data_i), .ext_pins(ext_pins));
  ext_mem_model partner (.ref_clk(ref_clk), .ext_pins(ext_pins), .port_hi(port_hi),
    .ext_data_i(ext_data_i), .last_addr(last_addr), .last_hi_oe(last_hi_oe),
    .strobe_len(strobe_len), .acc_cnt(acc_cnt));

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("FAIL at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : check

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sfr_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1 d = sfr_rdata;
  endtask : reg_rd

  task automatic set_tmg(input logic [7:0] v);
    tmg = v;
    reg_wr(TIMING_OFFSET, v);
  endtask : set_tmg

  task automatic set_cfg(input logic [1:0] m, input logic x, input logic [1:0] l);
    mode = m;
    mux = x;
    lw = l;
    reg_wr(CONFIG_OFFSET, {3'b000, x, m, l});
  endtask : set_cfg

  task automatic move(input logic wr, input logic wide, input logic [15:0] dp,
                      input logic [7:0] ind);
    exp_t x;
    logic [15:0] eff;
    logic [7:0] d;
    rnd = lfsr(rnd);
    d = rnd[7:0];
    eff = wide ? dp : {page, ind};
    x.rd = !wr;
    x.off = (mode == 2'b11) || (mode != 2'b00 && eff >= 16'h1000);
    x.hi = x.off && (wide || mode == 2'b10);
    x.addr = {x.hi ? eff[15:8] : port_hi, eff[7:0]};
    x.sw = {4'h0, tmg[5:2]} + 8'h01;
    // Latch phase only counts when multiplexed
    x.lat = x.off ? 8'(tmg[7:6]) + x.sw + 8'(tmg[1:0]) + 8'h04
                    + (mux ? {5'h00, lw, 1'b0} + 8'h02 : 8'h00) : 8'h03;
    if (wr && x.off) begin
      ext_sh[x.addr] = d;
    end else if (wr) begin
      int_sh[eff[11:0]] = d;
    end
    x.data = x.off ? ext_sh[x.addr] : int_sh[eff[11:0]];
    q.push_back(x);
    @(posedge ref_clk);
    move_valid <= 1'b1;
    move_req <= {wr, wide, dp, ind, d};
    @(posedge ref_clk);
    move_valid <= 1'b0;
    for (int n = 0; n < 100; n++) begin
      @(posedge ref_clk);
      if (move_done === 1'b1) break;
    end
  endtask : move

  // ****************************************************************
  // Result monitor and timeout
  // ****************************************************************
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (move_valid === 1'b1 && move_busy === 1'b0) begin
      t0 <= cyc;
    end
    if (move_done === 1'b1) begin
      e = q.pop_front();
      check(16'(cyc - t0), 16'(e.lat));
      check(16'(move_busy), 16'h0000);
      if (e.rd) check(16'(move_rdata), 16'(e.data));
      check(16'(acc_cnt - acc_prev), 16'(e.off));
      acc_prev = acc_cnt;
      if (e.off) begin
        check(last_addr, e.addr);
        check(16'(last_hi_oe), 16'(e.hi));
        check(16'(strobe_len), 16'(e.sw));
      end
    end
    if (cyc == 10000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [7:0] d;
    logic [7:0] pg;
    logic [15:0] dp;
    logic [10:0] tc;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_rd(TIMING_OFFSET, d);
    check(16'(d), 16'(TIMING_RESET));
    reg_rd(CONFIG_OFFSET, d);
    check(16'(d), 16'(CONFIG_RESET));
    reg_rd(8'h90, d);
    check(16'(d), 16'h0000);
    move(1'b1, 1'b1, 16'h0042, 8'h00);
    move(1'b0, 1'b1, 16'h0042, 8'h00);
    set_tmg(8'ha5);
    reg_rd(TIMING_OFFSET, d);
    check(16'(d), 16'h00a5);
    reg_wr(CONFIG_OFFSET, 8'hff);
    reg_rd(CONFIG_OFFSET, d);
    check(16'(d), 16'(CONFIG_MASK));
    $display("test registers done");
    set_tmg(8'h00);
    for (int i = 0; i < 8; i++) begin
      // upper port latches set before narrow moves
      port_hi <= rnd[23:16];
      set_cfg(2'(i / 2), 1'b0, 2'b00);
      pg = i[0] ? 8'h03 : 8'h12;
      page = pg;
      reg_wr(PAGE_OFFSET, pg);
      dp = {pg ^ (i < 2 ? 8'h30 : 8'h00), 8'h45};
      move(1'b1, 1'b1, {pg, 8'h45}, 8'h00);
      move(1'b0, 1'b1, dp, 8'h00);
      move(1'b1, 1'b0, 16'h0000, 8'h9c);
      move(1'b0, 1'b0, 16'h0000, 8'h9c);
    end
    $display("test modes done");
    for (int i = 0; i < 7; i++) begin
      tc = i < 4 ? tcase[i] : rnd[10:0];
      set_tmg(tc[7:0]);
      set_cfg(2'b11, tc[8], tc[10:9]);
      dp = rnd[31:16];
      move(1'b1, 1'b1, dp, 8'h00);
      move(1'b0, 1'b1, dp, 8'h00);
    end
    $display("test timing done");
    give_verdict();
  end
endmodule : ext_mem_ctrl_tb

// ### testbench/ext_mem_model.sv
/*
 * Behavioural external byte memory on the steered bus.
 * Assumes registered pins; port_hi is the level of the upper port latches.
 */
`timescale 1ns/10ps
module ext_mem_model
  import ext_mem_pkg::*;
(
  input wire logic ref_clk,
  input wire ext_pins_t ext_pins,
  input wire logic [7:0] port_hi,
  output logic [7:0] ext_data_i,
  output logic [15:0] last_addr,
  output logic last_hi_oe,
  output logic [7:0] strobe_len,
  output int acc_cnt
);
  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic [7:0] mem [0:65535];
  logic [7:0] lat_lo = 8'h00;
  logic [7:0] run = 8'h00;
  int hold = 0;
  logic strobe;
  logic [15:0] a;
  assign strobe = !ext_pins.rd_n || !ext_pins.wr_n;
  // Undriven upper lines show the port latch level
  assign a = {ext_pins.addr_hi_oe ? ext_pins.addr[15:8] : port_hi,
              ext_pins.addr_lo_oe ? ext_pins.addr[7:0] : lat_lo};
  initial begin
    ext_data_i = 8'h5a;
    acc_cnt = 0;
  end
  // Falling edge stands in for a part that answers while its strobe is low,
  // so read data is on the pins before the strobe's closing rising edge
  always @(negedge ref_clk) begin
    if (ext_pins.ale && ext_pins.data_oe) begin
      lat_lo <= ext_pins.data;
    end
    if (strobe) begin
      run <= run + 8'h01;
      last_addr <= a;
      last_hi_oe <= ext_pins.addr_hi_oe;
      hold <= 8;
      if (!ext_pins.wr_n) begin
        mem[a] <= ext_pins.data;
      end else begin
        ext_data_i <= mem[a];
      end
    end else begin
      if (run != 8'h00) begin
        acc_cnt <= acc_cnt + 1;
        strobe_len <= run;
        run <= 8'h00;
      end
      // Held past the strobe for the input synchroniser, then churns
      if (hold > 0) begin
        hold <= hold - 1;
      end else begin
        ext_data_i <= ~ext_data_i;
      end
    end
  end
endmodule : ext_mem_model
